// ### design/pgtm_monitor.sv
// Purpose: Output-ok line, enable line and thermal fault control
// Assumes: Sensor words come from ref_clk logic; pins are asynchronous
// Notes: Zero-wait AHB-Lite slave; status flags clear on read
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
// Contract
// - Primary drives output-ok; secondary only senses it after init
// - Out of window below 94 or above 106
// - Comparator result deglitched for 40 us
// - Undervoltage and overvoltage set their own flags
// - Window flags clear on read once condition ended
// - Blank comparator during voltage change when enabled
// - Hold output-ok low in fault and start states
// - All pull low in init; then primary only
// - Secondary sinks nothing until line high, then fixed-frequency
// - Secondary fault pulls enable low, not output-ok
// - Warning flag above 150, clears on read below 130
// - Above 170 stop, pull enable, discharge, flag
// - Below 150 restart soft start, release lines
// - Shutdown flag clears on read below 150
// - Shared enable stops and resumes whole stack
// - Sample clock-output pin at init for role
// - Clock-output pin pulled low means secondary
// - Clock-output pin floating high means primary
module pgtm_monitor #(
    parameter int VW = 12
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Converter core, same clock
    input wire logic [VW-1:0] vout_code,
    input wire logic [7:0] tj_code,
    input wire logic dynamic_voltage_change,
    input wire logic soft_start_done,
    input wire logic hiccup_active,
    input wire logic supply_low_lockout,
    input wire logic supply_high_lockout,
    input wire logic local_fault,
    // Shared pins
    input wire logic output_ok_line_i,
    output logic output_ok_line_o,
    output logic output_ok_line_oe,
    input wire logic enable_line_i,
    output logic enable_line_o,
    output logic enable_line_oe,
    input wire logic clk_out_pin_i,
    // Converter control
    output logic switching_en,
    output logic soft_start_req,
    output logic discharge_enable,
    output logic forced_fixed_frequency,
    output logic sink_allow,
    output logic role_primary
);
    import pgtm_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] pin_s1_ff;
    logic [2:0] pin_s2_ff;

    // Two flops for output-ok, enable and clock-output pins
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_ff <= 3'h0;
            pin_s2_ff <= 3'h0;
        end else begin
            pin_s1_ff <= {clk_out_pin_i, enable_line_i, output_ok_line_i};
            pin_s2_ff <= pin_s1_ff;
        end
    end
    wire logic ok_line = pin_s2_ff[0];
    wire logic en_line = pin_s2_ff[1];
    wire logic clk_out_lvl = pin_s2_ff[2];

    // ----------------------------------------------------------------
    // Registers and bus decode
    // ----------------------------------------------------------------
    logic [3:0] ctrl_ff;
    logic [VW-1:0] nominal_ff;
    logic [3:0] status_ff;
    logic [3:0] nxt_status;
    logic [31:0] hrdata_ff;
    logic [31:0] nxt_rdata;
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic role_primary_ff;
    logic fff_lat_ff;
    logic [11:0] init_cnt_ff;
    pgtm_state_t state_ff;
    pgtm_state_t nxt_state;

    // Address phase accepted on this edge
    wire logic acc = hsel && hready && htrans[1];
    wire logic rd_acc = acc && !hwrite;
    wire logic [7:0] a_ofs = haddr[7:0];
    wire logic rd_status = rd_acc && (a_ofs == OFS_STATUS);
    wire logic blank = ctrl_ff[CT_BLANK_BIT];
    wire logic single = ctrl_ff[CT_SINGLE_BIT];
    wire logic disch_bit = ctrl_ff[CT_DISCH_BIT];

    // ----------------------------------------------------------------
    // Window comparator and thermal compares
    // ----------------------------------------------------------------
    wire logic [18:0] v_scaled = 19'(vout_code) * PCT_FULL;
    wire logic [18:0] lo_lim = 19'(nominal_ff) * WIN_LO_PCT;
    wire logic [18:0] hi_lim = 19'(nominal_ff) * WIN_HI_PCT;
    wire logic under_raw = v_scaled < lo_lim;
    wire logic over_raw = v_scaled > hi_lim;
    wire logic blanked = blank && dynamic_voltage_change;
    wire logic win_raw = (under_raw || over_raw) && !blanked;
    wire logic win_bad;
    wire logic tj_warn = tj_code > TJ_WARN_SET;
    wire logic tj_warn_gone = tj_code < TJ_WARN_CLR;
    wire logic tj_hot = tj_code > TJ_SHUT_SET;
    wire logic tj_cool = tj_code < TJ_SHUT_CLR;
    wire logic lockout = supply_low_lockout || supply_high_lockout;

    // Deglitched out-of-window state
    pgtm_deglitch #(.CYC(DEGLITCH_CYC), .CW(12)) u_deglitch (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .raw(win_raw),
        .filt(win_bad)
    );

    // ----------------------------------------------------------------
    // Sticky status: set wins over clearing read
    // ----------------------------------------------------------------
    wire logic clr_win = rd_status && !win_bad && !win_raw;
    assign nxt_status[ST_UNDER_BIT] = (win_bad && under_raw)
        || (status_ff[ST_UNDER_BIT] && !clr_win);
    assign nxt_status[ST_OVER_BIT] = (win_bad && over_raw)
        || (status_ff[ST_OVER_BIT] && !clr_win);
    assign nxt_status[ST_THERMAL_WARNING_FLAG_BIT] = tj_warn
        || (status_ff[ST_THERMAL_WARNING_FLAG_BIT] && !(rd_status && tj_warn_gone));
    assign nxt_status[ST_THERMAL_SHUTDOWN_FLAG_BIT] = tj_hot
        || (status_ff[ST_THERMAL_SHUTDOWN_FLAG_BIT] && !(rd_status && tj_cool));

    // ----------------------------------------------------------------
    // Read mux, captured at the address phase
    // ----------------------------------------------------------------
    wire logic [31:0] rd_state = {24'h00_0000, 1'b0, ok_line, win_bad, role_primary_ff,
        1'b0, state_ff};
    assign nxt_rdata = (a_ofs == OFS_STATUS) ? {28'h000_0000, status_ff} :
        (a_ofs == OFS_CTRL) ? {28'h000_0000, ctrl_ff} :
        (a_ofs == OFS_NOMINAL) ? {20'h0_0000, nominal_ff} :
        (a_ofs == OFS_STATE) ? rd_state : 32'h0000_0000;

    // Bus registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata_ff <= 32'h0000_0000;
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            status_ff <= 4'h0;
        end else begin
            status_ff <= nxt_status;
            wr_pend_ff <= acc && hwrite;
            if (acc) begin
                wr_addr_ff <= a_ofs;
            end
            if (rd_acc) begin
                hrdata_ff <= nxt_rdata;
            end
        end
    end

    // Write data phase
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= CTRL_RST;
            nominal_ff <= NOMINAL_RST;
        end else if (wr_pend_ff) begin
            if (wr_addr_ff == OFS_CTRL) begin
                ctrl_ff <= hwdata[3:0];
            end
            if (wr_addr_ff == OFS_NOMINAL) begin
                nominal_ff <= hwdata[VW-1:0];
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;

    // ----------------------------------------------------------------
    // Operating state machine
    // ----------------------------------------------------------------
    wire logic init_end = init_cnt_ff == 12'(INIT_CYC - 1);

    // Thermal shutdown takes priority over lockout
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_INIT: begin
                if (init_end) begin
                    nxt_state = ST_OFF;
                end
            end
            ST_OFF, ST_SOFT, ST_RUN: begin
                if (tj_hot) begin
                    nxt_state = ST_HOT;
                end else if (lockout) begin
                    nxt_state = ST_LOCK;
                end else if (!en_line) begin
                    nxt_state = ST_OFF;
                end else if (state_ff == ST_OFF) begin
                    nxt_state = ST_SOFT;
                end else if (state_ff == ST_SOFT && soft_start_done) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_HOT: begin
                if (tj_cool) begin
                    nxt_state = ST_OFF;
                end
            end
            ST_LOCK: begin
                if (tj_hot) begin
                    nxt_state = ST_HOT;
                end else if (!lockout) begin
                    nxt_state = ST_OFF;
                end
            end
        endcase
    end

    // State, init timer, role and fixed-frequency latch
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ST_INIT;
            init_cnt_ff <= 12'h000;
            role_primary_ff <= 1'b1;
            fff_lat_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == ST_INIT) begin
                init_cnt_ff <= init_cnt_ff + 12'h001;
            end
            if (state_ff == ST_INIT && init_end) begin
                role_primary_ff <= clk_out_lvl;
            end
            if (state_ff != ST_SOFT && state_ff != ST_RUN) begin
                fff_lat_ff <= 1'b0;
            end else if (!role_primary_ff && ok_line) begin
                fff_lat_ff <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin drive and converter control
    // ----------------------------------------------------------------
    wire logic in_init = state_ff == ST_INIT;
    wire logic stopped = state_ff == ST_HOT || state_ff == ST_LOCK;
    wire logic hold_low = state_ff != ST_RUN || hiccup_active;
    wire logic pri_pull = role_primary_ff && (hold_low || win_bad);
    wire logic sec_fault = !role_primary_ff && local_fault;

    assign output_ok_line_o = 1'b0;
    assign output_ok_line_oe = in_init || pri_pull;
    assign enable_line_o = 1'b0;
    assign enable_line_oe = in_init || sec_fault
        || (stopped && !single);
    assign switching_en = (state_ff == ST_SOFT || state_ff == ST_RUN) && !hiccup_active;
    assign soft_start_req = state_ff == ST_OFF && nxt_state == ST_SOFT;
    assign discharge_enable = (stopped || state_ff == ST_OFF)
        && (disch_bit || !role_primary_ff);
    assign forced_fixed_frequency = role_primary_ff ? ctrl_ff[CT_FFF_BIT] : fff_lat_ff;
    assign sink_allow = role_primary_ff || fff_lat_ff;
    assign role_primary = role_primary_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_hot_seen;
        tj_hot && state_ff != ST_INIT;
    endsequence
    sequence s_shut_held;
        state_ff == ST_HOT && !switching_en;
    endsequence

    AST_HOT_STOPS: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_hot_seen |=> s_shut_held ##0 status_ff[ST_THERMAL_SHUTDOWN_FLAG_BIT])
        else $error("overtemperature did not stop switching");
    AST_HOT_PULLS_EN: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state_ff == ST_HOT && !single |-> enable_line_oe && !enable_line_o)
        else $error("enable line not pulled in shutdown");
    AST_OK_LOW_STOPPED: assert property (@(posedge ref_clk) disable iff (!rst_b)
        role_primary_ff && (state_ff != ST_RUN || hiccup_active) |-> output_ok_line_oe)
        else $error("output-ok released in a hold-low state");
    AST_SEC_NO_DRIVE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !role_primary_ff && state_ff != ST_INIT |-> !output_ok_line_oe)
        else $error("secondary drove output-ok after init");
    AST_INIT_PULL: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state_ff == ST_INIT |-> output_ok_line_oe && enable_line_oe)
        else $error("lines not pulled during init");
    AST_WIN_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        status_ff[ST_UNDER_BIT] && rd_status && win_bad |=> status_ff[ST_UNDER_BIT])
        else $error("under flag cleared while condition present");
    AST_THERMAL_WARNING_FLAG_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_b)
        status_ff[ST_THERMAL_WARNING_FLAG_BIT] && !tj_warn_gone |=> status_ff[ST_THERMAL_WARNING_FLAG_BIT])
        else $error("warning flag cleared above release point");
    AST_THERMAL_SHUTDOWN_FLAG_CLR: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(status_ff[ST_THERMAL_SHUTDOWN_FLAG_BIT]) |-> $past(rd_status) && $past(tj_cool))
        else $error("shutdown flag cleared without read when cool");
    AST_COOL_RESTART: assert property (@(posedge ref_clk) disable iff (!rst_b)
        state_ff == ST_HOT && tj_cool |=> state_ff == ST_OFF ##0 !enable_line_oe || sec_fault || lockout
        || state_ff != ST_OFF)
        else $error("no restart after cooling");
    AST_SEC_SINK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !role_primary_ff && !ok_line && !fff_lat_ff |-> !sink_allow)
        else $error("secondary allowed sinking while line low");
    AST_BLANK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        blank && dynamic_voltage_change |-> !win_raw)
        else $error("comparator not blanked during voltage change");
endmodule

// ### shared/pgtm_pkg.sv
// Purpose: Shared constants for the power-good and thermal monitor block
// Assumes: 40 MHz ref_clk; 32-bit AHB-Lite register bus
// Notes: Offsets are byte addresses; temperatures are in whole degrees C
package pgtm_pkg;
    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int DEGLITCH_US = 40;
    localparam int DEGLITCH_CYC = DEGLITCH_US * CLK_MHZ;
    localparam int INIT_US = 10;
    localparam int INIT_CYC = INIT_US * CLK_MHZ;

    // ----------------------------------------------------------------
    // Window comparator and thermal thresholds
    // ----------------------------------------------------------------
    localparam logic [18:0] WIN_LO_PCT = 19'h0_005E; // 94 percent
    localparam logic [18:0] WIN_HI_PCT = 19'h0_006A; // 106 percent
    localparam logic [18:0] PCT_FULL = 19'h0_0064;   // 100 percent
    localparam logic [7:0] TJ_WARN_SET = 8'h96;      // 150 C
    localparam logic [7:0] TJ_WARN_CLR = 8'h82;      // 130 C
    localparam logic [7:0] TJ_SHUT_SET = 8'hAA;      // 170 C
    localparam logic [7:0] TJ_SHUT_CLR = 8'h96;      // 150 C

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_NOMINAL = 8'h08;
    localparam logic [7:0] OFS_STATE = 8'h0C;

    // Status bits
    localparam int ST_UNDER_BIT = 0;
    localparam int ST_OVER_BIT = 1;
    localparam int ST_THERMAL_WARNING_FLAG_BIT = 2;
    localparam int ST_THERMAL_SHUTDOWN_FLAG_BIT = 3;

    // Control bits
    localparam int CT_BLANK_BIT = 0;
    localparam int CT_SINGLE_BIT = 1;
    localparam int CT_DISCH_BIT = 2;
    localparam int CT_FFF_BIT = 3;

    // Reset values
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [11:0] NOMINAL_RST = 12'h0_3E8;

    // Operating states
    typedef enum logic [2:0] {
        ST_INIT, ST_OFF, ST_SOFT, ST_RUN, ST_HOT, ST_LOCK
    } pgtm_state_t;
endpackage

// ### design/pgtm_deglitch.sv
// Purpose: Stability filter for the window comparator result
// Assumes: raw comes from logic on ref_clk
// Notes: Output follows raw only after raw held steady for CYC cycles
`timescale 1ns/1ps
module pgtm_deglitch #(
    parameter int CYC = pgtm_pkg::DEGLITCH_CYC,
    parameter int CW = 12
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic raw,
    output logic filt
);
    import pgtm_pkg::*;

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic filt_ff;
    logic nxt_filt;
    wire logic differs = raw != filt_ff;
    wire logic done = cnt_ff == CW'(CYC - 1);

    // ----------------------------------------------------------------
    // Counter restarts whenever raw agrees with the output
    // ----------------------------------------------------------------
    assign nxt_cnt = (differs && !done) ? cnt_ff + 1'b1 : '0;
    assign nxt_filt = (differs && done) ? raw : filt_ff;
    assign filt = filt_ff;

    // State registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= '0;
            filt_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            filt_ff <= nxt_filt;
        end
    end

    // Output moves only after the full interval of steady input
    AST_FILT_NEEDS_COUNT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $changed(filt_ff) |-> $past(done) && $past(differs))
        else $error("filter output moved before the interval ended");
    // Input that agrees with the output never moves it
    AST_FILT_STEADY: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !differs ##1 !differs |-> $stable(filt_ff))
        else $error("filter output moved while input agreed");
endmodule

// ### sim/pgtm_stack_peer.sv
// Purpose: Behavioural model of another converter unit in the stack
// Assumes: Shares ref_clk with the bench; lines have pull-ups in the bench
// Notes: Pulls output-ok low through its own init, then only on command
`timescale 1ns/1ps
module pgtm_stack_peer (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic hold_ok_low,
    input wire logic pull_en_low,
    output logic ok_oe,
    output logic en_oe
);
    import pgtm_pkg::*;
    int init_cnt;
    // ----------------------------------------------------------------
    // Init timer
    // ----------------------------------------------------------------
    // Counts this unit's own initialisation after reset
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            init_cnt <= 0;
        end else if (init_cnt < INIT_CYC) begin
            init_cnt <= init_cnt + 1;
        end
    end
    // Every unit pulls output-ok low while it initialises, primary holds it after
    assign ok_oe = (init_cnt < INIT_CYC) || hold_ok_low;
    // A faulted or hot unit stops the stack through the shared enable
    assign en_oe = pull_en_low;
endmodule

// ### sim/power_good_thermal_monitor_test.sv
// Purpose: Self-checking bench for the output-ok and thermal monitor
// Assumes: One peer unit on the shared lines, both lines pulled up
// Notes: Deglitch runs at full length; run takes about 17.6k cycles
`timescale 1ns/1ps
module power_good_thermal_monitor_test;
    import pgtm_pkg::*;
    logic ref_clk = 0, rst_b = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic [11:0] vout_code = 12'h3E8;
    logic [7:0] tj_code = 8'h19;
    logic dvc = 0, ss_done = 0, hiccup = 0, lo_lock = 0, hi_lock = 0, local_fault = 0, clk_pin = 1;
    logic peer_ok = 0, peer_en = 0, ok_oe, ok_o, en_oe, en_o, ok_oe_p, en_oe_p;
    logic sw_en, ss_req, disch, fff, sink, role;
    wire ok_line = !(ok_oe | ok_oe_p);
    wire en_line = !(en_oe | en_oe_p);
    int mismatches = 0, check_count = 0, ss_cnt = 0;
    assign hready = hreadyout;
    // ----------------------------------------------------------------
    // Clock, design and peer
    // ----------------------------------------------------------------
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    pgtm_monitor #(.VW(12)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .vout_code(vout_code), .tj_code(tj_code),
        .dynamic_voltage_change(dvc), .soft_start_done(ss_done), .hiccup_active(hiccup),
        .supply_low_lockout(lo_lock), .supply_high_lockout(hi_lock), .local_fault(local_fault),
        .output_ok_line_i(ok_line), .output_ok_line_o(ok_o), .output_ok_line_oe(ok_oe),
        .enable_line_i(en_line), .enable_line_o(en_o), .enable_line_oe(en_oe), .clk_out_pin_i(clk_pin),
        .switching_en(sw_en), .soft_start_req(ss_req), .discharge_enable(disch),
        .forced_fixed_frequency(fff), .sink_allow(sink), .role_primary(role));
    pgtm_stack_peer u_peer (.ref_clk(ref_clk), .rst_b(rst_b), .hold_ok_low(peer_ok),
        .pull_en_low(peer_en), .ok_oe(ok_oe_p), .en_oe(en_oe_p));
    // Counts soft-start requests for the restart check
    always @(posedge ref_clk) begin
        if (ss_req === 1'b1) begin
            ss_cnt++;
        end
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // One AHB-Lite single word transfer, waits on hready in both phases
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge ref_clk);
        while (hready !== 1'b1) begin
            @(posedge ref_clk);
        end
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd = hrdata;
        chk(32'(hresp), 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r & m, e);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        cyc(1);
        chk(32'({ok_oe, en_oe, sw_en}), 32'h6);
        chk(32'({ok_o, en_o}), 32'h0);
        rdchk(OFS_CTRL, 32'hFFFF_FFFF, 32'h0);
        rdchk(OFS_NOMINAL, 32'hFFFF_FFFF, 32'h3E8);
        rdchk(8'h10, 32'hFFFF_FFFF, 32'h0);
        rdchk(OFS_STATE, 32'h7, 32'(ST_INIT));
        cyc(INIT_CYC + 10);
        rdchk(OFS_STATE, 32'h17, 32'h10 | 32'(ST_SOFT));
        chk(32'(ok_oe), 32'h1);
        @(posedge ref_clk) ss_done <= 1'b1;
        cyc(6);
        chk(32'({ok_oe, sw_en}), 32'h1);
    endtask
    task automatic t_window(input logic [11:0] v, input logic [31:0] flag);
        @(posedge ref_clk) vout_code <= v;
        cyc(1590);
        chk(32'(ok_oe), 32'h0);
        cyc(30);
        chk(32'(ok_oe), 32'(flag != 0));
        rdchk(OFS_STATUS, 32'hF, flag);
        rdchk(OFS_STATUS, 32'hF, flag);
        @(posedge ref_clk) vout_code <= 12'h3E8;
        cyc(1650);
        chk(32'(ok_oe), 32'h0);
        rdchk(OFS_STATUS, 32'hF, flag);
        rdchk(OFS_STATUS, 32'hF, 32'h0);
    endtask
    task automatic t_blank();
        wr(OFS_CTRL, 32'h1);
        @(posedge ref_clk) dvc <= 1'b1;
        @(posedge ref_clk) vout_code <= 12'h384;
        cyc(1700);
        chk(32'(ok_oe), 32'h0);
        @(posedge ref_clk) vout_code <= 12'h3E8;
        cyc(1700);
        @(posedge ref_clk) dvc <= 1'b0;
        wr(OFS_CTRL, 32'h0);
        rdchk(OFS_STATE, 32'h20, 32'h0);
        rdchk(OFS_STATUS, 32'hF, 32'h0);
    endtask
    task automatic t_faults();
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk) {peer_en, hiccup, hi_lock, lo_lock} <= 4'(1 << i);
            cyc(6);
            chk(32'({ok_oe, sw_en}), 32'h2);
            @(posedge ref_clk) {peer_en, hiccup, hi_lock, lo_lock} <= 4'h0;
            cyc(12);
            chk(32'({ok_oe, sw_en}), 32'h1);
        end
    endtask
    task automatic t_thermal();
        int c;
        wr(OFS_CTRL, 32'h4);
        @(posedge ref_clk) tj_code <= 8'h97;
        cyc(4);
        rdchk(OFS_STATUS, 32'hF, 32'h4);
        @(posedge ref_clk) tj_code <= 8'hAB;
        cyc(4);
        chk(32'({sw_en, en_oe, ok_oe, disch}), 32'h7);
        @(posedge ref_clk) tj_code <= 8'hA0;
        cyc(4);
        rdchk(OFS_STATUS, 32'hF, 32'hC);
        rdchk(OFS_STATUS, 32'hF, 32'hC);
        c = ss_cnt;
        @(posedge ref_clk) tj_code <= 8'h95;
        cyc(8);
        chk(32'({en_oe, ok_oe, sw_en}), 32'h1);
        chk(32'(ss_cnt > c), 32'h1);
        rdchk(OFS_STATUS, 32'hF, 32'hC);
        rdchk(OFS_STATUS, 32'hF, 32'h4);
        @(posedge ref_clk) tj_code <= 8'h81;
        cyc(4);
        rdchk(OFS_STATUS, 32'hF, 32'h4);
        rdchk(OFS_STATUS, 32'hF, 32'h0);
        wr(OFS_CTRL, 32'h2);
        @(posedge ref_clk) tj_code <= 8'hAB;
        cyc(4);
        chk(32'({en_oe, ok_oe}), 32'h1);
        @(posedge ref_clk) tj_code <= 8'h19;
        cyc(8);
    endtask
    task automatic t_second();
        @(posedge ref_clk) rst_b <= 1'b0;
        @(posedge ref_clk) clk_pin <= 1'b0;
        @(posedge ref_clk) peer_ok <= 1'b1;
        cyc(6);
        @(posedge ref_clk) rst_b <= 1'b1;
        cyc(2);
        chk(32'({ok_oe, en_oe, sw_en}), 32'h6);
        cyc(INIT_CYC + 8);
        chk(32'({role, ok_oe, sink}), 32'h0);
        rdchk(OFS_STATE, 32'h10, 32'h0);
        @(posedge ref_clk) peer_ok <= 1'b0;
        cyc(8);
        chk(32'({sink, fff}), 32'h3);
        @(posedge ref_clk) local_fault <= 1'b1;
        cyc(6);
        chk(32'({en_oe, ok_oe}), 32'h2);
    endtask
    // ----------------------------------------------------------------
    // Verdict and main sequence
    // ----------------------------------------------------------------
    task automatic test_done();
        if (mismatches == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Cuts a hang short at over three times the expected run
    initial begin
        repeat (60000) @(posedge ref_clk);
        mismatches++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_reset();
        t_window(12'h3AB, 32'h1);
        t_window(12'h425, 32'h2);
        t_window(12'h3AC, 32'h0);
        t_window(12'h424, 32'h0);
        t_blank();
        t_faults();
        t_thermal();
        t_second();
        test_done();
    end
endmodule
